// >>> hdl/ldd_decode.sv
// ldd_decode: host i/o cycle decoder for config port and logical devices
//
// Contract
// - base compare uses address bits 11..0
// - qualification bit set requires A15..A12 zero
// - strap picks config port 0x02E or 0x04E
// - writes to 0x26/0x27 move the config port
// - parallel epp ports need 8-byte alignment; extended registers decode on 4- or 8-byte aligned bases
// - keyboard fixed at 0x60 and 0x64
// - base set through indices 0x60 and 0x61
// - out-of-range base ignores that device's cycles
// - device decodes only while active
`timescale 1ns/1ps
`default_nettype none
module ldd_decode (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // straps and power control
  input  wire logic                 power_up_port_strap,
  input  wire logic [ldd_pkg::LDD_NUM_DEV-1:0] pwr_ctl_on,
  // host i/o cycle
  input  wire logic                 io_req,
  input  wire logic                 io_wr,
  input  wire logic [15:0]          io_addr,
  input  wire logic [7:0]           io_wdata,
  // decode result
  output logic                      io_ack,
  output logic                      io_claim,
  output logic                      cfg_sel,
  output logic [ldd_pkg::LDD_NUM_DEV-1:0] dev_sel,
  output logic [11:0]               dev_offset,
  output logic [7:0]                io_rdata,
  output logic [ldd_pkg::LDD_NUM_DEV-1:0] dev_active
);
  import ldd_pkg::*;

  typedef struct packed {
    logic [15:0]                   cfg_port;
    logic [7:0]                    index;
    logic [3:0]                    ldn;
    logic [7:0]                    osc;
    logic [LDD_NUM_DEV-1:0]        act;
    logic [LDD_NUM_DEV-1:0][15:0]  base;
    logic                          ack;
    logic                          claim;
    logic                          cfg;
    logic [LDD_NUM_DEV-1:0]        sel;
    logic [11:0]                   offset;
    logic [7:0]                    rdata;
  } ldd_state_s;

  ldd_state_s st_r;
  ldd_state_s st_nxt;

  // only these devices carry a programmable base
  function automatic logic relocatable(input logic [3:0] d);
    relocatable = (d == LDD_DEV_FLOPPY) || (d == LDD_DEV_PARALLEL) ||
                  (d == LDD_DEV_SERIAL1) || (d == LDD_DEV_SERIAL2) ||
                  (d == LDD_DEV_RUNTIME) || (d == LDD_DEV_SMBUS);
  endfunction

  // base legality per device; upper nibble must be clear
  function automatic logic base_ok(input logic [3:0]  d,
                                   input logic [15:0] b);
    logic [11:0] a;
    a = b[11:0];
    base_ok = 1'b0;
    if (b[15:12] == 4'h0) begin
      case (d)
        LDD_DEV_RUNTIME:
          base_ok = (a <= LDD_RT_MAX) && (a[6:0] == 7'h00);
        LDD_DEV_PARALLEL:
          base_ok = (a >= LDD_STD_MIN) && (a <= LDD_PAR_MAX) &&
                    (a[1:0] == 2'b00);
        default:
          base_ok = relocatable(d) && (a >= LDD_STD_MIN) &&
                    (a <= LDD_STD_MAX) && (a[2:0] == 3'b000);
      endcase
    end
  endfunction

  logic [11:0] a12;
  logic        qual_ok;
  logic [11:0] diff;
  logic        hit;
  logic [3:0]  di;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.ack   = io_req;
    st_nxt.claim = 1'b0;
    st_nxt.cfg   = 1'b0;
    st_nxt.sel   = '0;
    st_nxt.offset = 12'h000;
    st_nxt.rdata = LDD_RESET_BYTE;
    a12     = io_addr[11:0];
    qual_ok = !st_r.osc[LDD_QUAL_BIT] || (io_addr[15:12] == 4'h0);
    diff    = 12'h000;
    hit     = 1'b0;
    di      = 4'h0;
    for (int i = 0; i < LDD_NUM_DEV; i++) begin
      di   = 4'(i);
      diff = a12 - st_r.base[i][11:0];
      hit  = 1'b0;
      if (di == LDD_DEV_KEYBOARD) begin
        hit = (a12 == LDD_KBD_DATA) || (a12 == LDD_KBD_CMD);
        diff = a12 - LDD_KBD_DATA;
      end else if (base_ok(di, st_r.base[i])) begin
        case (di)
          LDD_DEV_RUNTIME:
            hit = (diff[11:7] == 5'h00);
          LDD_DEV_PARALLEL:
            // epp ports only exist on an 8-byte aligned base
            if (st_r.base[i][2] == 1'b0) begin
              hit = (diff[11:3] == 9'h000) ||
                    ((diff >= LDD_PAR_EXT) && (diff <= LDD_PAR_EXT_LAST));
            end else begin
              hit = (diff <= LDD_PAR_SPP_LAST) ||
                    ((diff >= LDD_PAR_EXT) &&
                     (diff <= LDD_PAR_EXT_LAST));
            end
          default:
            hit = (diff[11:3] == 9'h000);
        endcase
      end
      // lowest device number wins if two windows overlap
      if (io_req && qual_ok && st_r.act[i] && hit && !st_nxt.claim &&
          !st_nxt.cfg) begin
        st_nxt.claim  = 1'b1;
        st_nxt.sel[i] = 1'b1;
        st_nxt.offset = diff;
      end
    end

    // config port takes priority over any device window
    if (io_req && qual_ok &&
        (a12[11:1] == st_r.cfg_port[11:1])) begin
      st_nxt.claim  = 1'b1;
      st_nxt.cfg    = 1'b1;
      st_nxt.sel    = '0;
      st_nxt.offset = {11'h000, a12[0]};
      if (a12[0] == 1'b0) begin
        if (io_wr) begin
          st_nxt.index = io_wdata;
        end else begin
          st_nxt.rdata = st_r.index;
        end
      end else if (io_wr) begin
        case (st_r.index)
          LDD_IDX_LDN:     st_nxt.ldn = io_wdata[3:0];
          LDD_IDX_OSC:     st_nxt.osc = io_wdata;
          LDD_IDX_RELOC_A: st_nxt.cfg_port[7:0] = io_wdata;
          LDD_IDX_RELOC_B: st_nxt.cfg_port[15:8] = io_wdata;
          LDD_IDX_ACTIVATE:
            if (st_r.ldn < 4'(LDD_NUM_DEV)) begin
              st_nxt.act[st_r.ldn] = io_wdata[LDD_ACT_BIT];
            end
          LDD_IDX_BASE_HI:
            if (relocatable(st_r.ldn)) begin
              st_nxt.base[st_r.ldn][15:8] = io_wdata;
            end
          LDD_IDX_BASE_LO:
            if (relocatable(st_r.ldn)) begin
              st_nxt.base[st_r.ldn][7:0] = io_wdata;
            end
          default: ;
        endcase
      end else begin
        case (st_r.index)
          LDD_IDX_LDN:     st_nxt.rdata = {4'h0, st_r.ldn};
          LDD_IDX_OSC:     st_nxt.rdata = st_r.osc;
          LDD_IDX_RELOC_A: st_nxt.rdata = st_r.cfg_port[7:0];
          LDD_IDX_RELOC_B: st_nxt.rdata = st_r.cfg_port[15:8];
          LDD_IDX_ACTIVATE:
            if (st_r.ldn < 4'(LDD_NUM_DEV)) begin
              st_nxt.rdata = {7'h00, st_r.act[st_r.ldn] |
                              pwr_ctl_on[st_r.ldn]};
            end
          LDD_IDX_BASE_HI:
            if (relocatable(st_r.ldn)) begin
              st_nxt.rdata = st_r.base[st_r.ldn][15:8];
            end
          LDD_IDX_BASE_LO:
            if (relocatable(st_r.ldn)) begin
              st_nxt.rdata = st_r.base[st_r.ldn][7:0];
            end
          default: ;
        endcase
      end
    end

    // activate and power control are linked: either turns a device on
    // folding pwr_ctl_on into act keeps a device on after the pin drops
    st_nxt.act = st_nxt.act | pwr_ctl_on;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r          <= '0;
      st_r.cfg_port <= power_up_port_strap ? LDD_CFG_PORT_HIGH
                                           : LDD_CFG_PORT_LOW;
      st_r.base     <= {LDD_NUM_DEV{LDD_RESET_BASE}};
      st_r.rdata    <= LDD_RESET_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    io_ack     = st_r.ack;
    io_claim   = st_r.claim;
    cfg_sel    = st_r.cfg;
    dev_sel    = st_r.sel;
    dev_offset = st_r.offset;
    io_rdata   = st_r.rdata;
    dev_active = st_r.act;
  end
endmodule
`default_nettype wire

// >>> hdl/ldd_pkg.sv
// ldd_pkg: constants for the logical device i/o decoder
package ldd_pkg;
  localparam int          LDD_NUM_DEV      = 12;
  // configuration port locations selected by the power-up strap
  localparam logic [15:0] LDD_CFG_PORT_LOW  = 16'h002E;
  localparam logic [15:0] LDD_CFG_PORT_HIGH = 16'h004E;
  // global configuration register indices
  localparam logic [7:0]  LDD_IDX_LDN      = 8'h07;
  localparam logic [7:0]  LDD_IDX_OSC      = 8'h24;
  localparam logic [7:0]  LDD_IDX_RELOC_A  = 8'h26;
  localparam logic [7:0]  LDD_IDX_RELOC_B  = 8'h27;
  // per logical device register indices
  localparam logic [7:0]  LDD_IDX_ACTIVATE = 8'h30;
  localparam logic [7:0]  LDD_IDX_BASE_HI  = 8'h60;
  localparam logic [7:0]  LDD_IDX_BASE_LO  = 8'h61;
  localparam int          LDD_QUAL_BIT     = 6;
  localparam int          LDD_ACT_BIT      = 0;
  // logical device numbers
  localparam logic [3:0]  LDD_DEV_FLOPPY   = 4'h0;
  localparam logic [3:0]  LDD_DEV_PARALLEL = 4'h3;
  localparam logic [3:0]  LDD_DEV_SERIAL1  = 4'h4;
  localparam logic [3:0]  LDD_DEV_SERIAL2  = 4'h5;
  localparam logic [3:0]  LDD_DEV_KEYBOARD = 4'h7;
  localparam logic [3:0]  LDD_DEV_RUNTIME  = 4'hA;
  localparam logic [3:0]  LDD_DEV_SMBUS    = 4'hB;
  // permitted base ranges
  localparam logic [11:0] LDD_STD_MIN      = 12'h100;
  localparam logic [11:0] LDD_STD_MAX      = 12'hFF8;
  localparam logic [11:0] LDD_PAR_MAX      = 12'hFFC;
  localparam logic [11:0] LDD_RT_MAX       = 12'hF80;
  localparam logic [11:0] LDD_CFG_MAX      = 12'hFFE;
  // fixed keyboard addresses
  localparam logic [11:0] LDD_KBD_DATA     = 12'h060;
  localparam logic [11:0] LDD_KBD_CMD      = 12'h064;
  // parallel port extended register window
  localparam logic [11:0] LDD_PAR_EXT      = 12'h400;
  localparam logic [11:0] LDD_PAR_EXT_LAST = 12'h402;
  localparam logic [11:0] LDD_PAR_SPP_LAST = 12'h002;
  localparam logic [15:0] LDD_RESET_BASE   = 16'h0000;
  localparam logic [7:0]  LDD_RESET_BYTE   = 8'h00;
endpackage

// >>> verif/ldd_decode_chk.sv
// ldd_decode_chk: port-level assertions for the i/o decoder
`timescale 1ns/1ps
`default_nettype none
module ldd_decode_chk (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 reset,
  // host cycle
  input wire logic                 io_req,
  input wire logic [15:0]          io_addr,
  // decode result
  input wire logic                 io_ack,
  input wire logic                 io_claim,
  input wire logic                 cfg_sel,
  input wire logic [ldd_pkg::LDD_NUM_DEV-1:0] dev_sel,
  input wire logic [11:0]          dev_offset,
  input wire logic [7:0]           io_rdata,
  input wire logic [ldd_pkg::LDD_NUM_DEV-1:0] dev_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_ack; io_req |=> io_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_idle; !io_ack |-> !io_claim && !cfg_sel && dev_sel == 0;
  endproperty
  a_idle: assert property (p_idle) else $error("stray select");
  property p_kbd; io_req && dev_active[7] &&
    (io_addr == 16'h0060 || io_addr == 16'h0064) |=> dev_sel[7] &&
    dev_offset == ($past(io_addr) == 16'h0064 ? 12'h004 : 12'h000);
  endproperty
  a_kbd: assert property (p_kbd) else $error("kbd decode");
  property p_act; io_ack |-> (dev_sel & ~dev_active) == 0; endproperty
  a_act: assert property (p_act) else $error("inactive hit");
  property p_claim; io_ack |-> io_claim == (cfg_sel || dev_sel != 0);
  endproperty
  a_claim: assert property (p_claim) else $error("claim");
  property p_cfg; cfg_sel |-> dev_sel == 0 && dev_offset <= 12'h001;
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg port");
  property p_par; dev_sel[3] |->
    dev_offset inside {[12'h000:12'h007], [12'h400:12'h402]}; endproperty
  a_par: assert property (p_par) else $error("par window");
  property p_rt; dev_sel[10] |-> dev_offset < 12'h080; endproperty
  a_rt: assert property (p_rt) else $error("rt window");
  property p_std; dev_sel[0] || dev_sel[4] || dev_sel[5] || dev_sel[11]
    |-> dev_offset < 12'h008; endproperty
  a_std: assert property (p_std) else $error("8-byte window");
  property p_rd; !cfg_sel |-> io_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("rdata");
endmodule
bind ldd_decode ldd_decode_chk u_ldd_decode_chk (.clk, .reset, .io_req,
  .io_addr, .io_ack, .io_claim, .cfg_sel, .dev_sel, .dev_offset,
  .io_rdata, .dev_active);
`default_nettype wire

// >>> verif/ldd_host.sv
// ldd_host: host model issuing one-cycle i/o requests
`timescale 1ns/1ps
`default_nettype none
module ldd_host (
  // clock
  input  wire logic        clk,
  // i/o cycle
  output var  logic        io_req,
  output var  logic        io_wr,
  output var  logic [15:0] io_addr,
  output var  logic [7:0]  io_wdata
);
  initial begin
    io_req = 1'b0;
    io_wr = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
  end
  // idle address and data lines show the inverse so a stale value never decodes by chance
  task automatic cyc(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    @(negedge clk);
    io_req = 1'b1;
    io_wr = w;
    io_addr = a;
    io_wdata = d;
    @(negedge clk);
    io_req = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_ldd_decode.sv
// tb_ldd_decode: random and corner tests for the i/o decoder
`timescale 1ns/1ps
`default_nettype none
module tb_ldd_decode;
  import ldd_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        strap = 1'b0;
  logic [11:0] pwr_ctl_on = 12'h000;
  wire logic   io_req;
  wire logic   io_wr;
  wire logic [15:0] io_addr;
  wire logic [7:0]  io_wdata;
  logic        io_ack, io_claim, cfg_sel;
  logic [11:0] dev_sel, dev_offset, dev_active, o;
  logic [7:0]  io_rdata;
  logic [15:0] cp, fb, np;
  int          error_cnt = 0, compares = 0, cyc_cnt = 0;
  ldd_decode u_ldd_decode (.clk, .reset, .power_up_port_strap(strap),
    .pwr_ctl_on, .io_req, .io_wr, .io_addr, .io_wdata, .io_ack,
    .io_claim, .cfg_sel, .dev_sel, .dev_offset, .io_rdata, .dev_active);
  ldd_host u_ldd_host (.clk, .io_req, .io_wr, .io_addr, .io_wdata);
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 4000) begin
      error_cnt++;
      wrap_up();
    end
  end
  function automatic logic [15:0] port_of(logic s);
    return s ? LDD_CFG_PORT_HIGH : LDD_CFG_PORT_LOW;
  endfunction
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic rst(logic s);
    strap = s;
    reset = 1'b1;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    cp = port_of(s);
  endtask
  // index first, then data one address up
  task automatic cw(logic [7:0] i, logic [7:0] v);
    u_ldd_host.cyc(1'b1, cp, i);
    u_ldd_host.cyc(1'b1, cp + 16'h0001, v);
  endtask
  task automatic rd(logic [7:0] i, logic [7:0] e);
    u_ldd_host.cyc(1'b1, cp, i);
    u_ldd_host.cyc(1'b0, cp + 16'h0001, 8'h00);
    chk("cfg_sel", cfg_sel, 1'b1);
    chk("rdata", io_rdata, e);
  endtask
  task automatic hit(logic [15:0] a, int n, logic [11:0] off);
    u_ldd_host.cyc(1'b0, a, 8'h00);
    chk("ack", io_ack, 1'b1);
    chk("claim", io_claim, n >= 0);
    chk("sel", dev_sel, n < 0 ? 12'h000 : 12'h001 << n);
    if (n >= 0) chk("off", dev_offset, off);
  endtask
  task automatic dev(logic [3:0] n, logic [15:0] b);
    cw(LDD_IDX_LDN, {4'h0, n});
    cw(LDD_IDX_BASE_HI, b[15:8]);
    cw(LDD_IDX_BASE_LO, b[7:0]);
    cw(LDD_IDX_ACTIVATE, 8'h01);
  endtask
  initial begin
    void'($urandom(32'h6313));
    rst(1'b1);
    rd(LDD_IDX_BASE_HI, 8'h00);
    hit(LDD_CFG_PORT_LOW, -1, 12'h000);
    rst(1'b0);
    hit(LDD_CFG_PORT_HIGH, -1, 12'h000);
    np = 16'h0F00 | 16'($urandom & 8'hFE);
    cw(LDD_IDX_RELOC_A, np[7:0]);
    cp[7:0] = np[7:0];
    cw(LDD_IDX_RELOC_B, np[15:8]);
    cp[15:8] = np[15:8];
    hit(LDD_CFG_PORT_LOW, -1, 12'h000);
    rd(LDD_IDX_RELOC_A, np[7:0]);
    fb = 16'h0800 + 16'($urandom % 224) * 16'h0008;
    dev(LDD_DEV_FLOPPY, fb);
    repeat (8) begin
      o = 12'($urandom % 8);
      hit(fb + 16'(o), 0, o);
    end
    chk("active", dev_active[0], 1'b1);
    rd(LDD_IDX_BASE_LO, fb[7:0]);
    cw(LDD_IDX_OSC, 8'h40);
    hit(fb | 16'h1000, -1, 12'h000);
    cw(LDD_IDX_OSC, 8'h00);
    hit(fb | 16'h1000, 0, 12'h000);
    cw(LDD_IDX_ACTIVATE, 8'h00);
    hit(fb, -1, 12'h000);
    dev(LDD_DEV_FLOPPY, 16'h0080);
    hit(16'h0080, -1, 12'h000);
    dev(LDD_DEV_PARALLEL, 16'h0378);
    hit(16'h037B, 3, 12'h003);
    hit(16'h0779, 3, 12'h401);
    dev(LDD_DEV_PARALLEL, 16'h037C);
    hit(16'h037F, -1, 12'h000);
    hit(16'h037E, 3, 12'h002);
    dev(LDD_DEV_RUNTIME, 16'h0080);
    hit(16'h00FF, 10, 12'h07F);
    hit(16'h0100, -1, 12'h000);
    hit(16'h0060, -1, 12'h000);
    pwr_ctl_on = 12'h080;
    hit(16'h0060, 7, 12'h000);
    hit(16'h0064, 7, 12'h004);
    wrap_up();
  end
endmodule
`default_nettype wire
